/* core/pccs_pkg.sv */
// constants for the configuration command and status register pair
`default_nettype none
package pccs_pkg;
    localparam int CFG_AW = 12;
    localparam logic [11:0] CMD_OFF = 12'h004;
    localparam logic [11:0] STS_OFF = 12'h006;
    // command bit positions
    localparam int CMD_INT_DIS = 10;
    localparam int CMD_FAST_B2B = 9;
    localparam int CMD_ERR_REP = 8;
    localparam int CMD_STEP = 7;
    localparam int CMD_PAR_RESP = 6;
    localparam int CMD_PALETTE = 5;
    localparam int CMD_WR_INV = 4;
    localparam int CMD_SPECIAL = 3;
    localparam int CMD_BUS_MST = 2;
    localparam int CMD_MEM_EN = 1;
    localparam int CMD_IO_EN = 0;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] CMD_RW_MASK = 16'h0546;
    // status bit positions
    localparam int STS_DET_PAR = 15;
    localparam int STS_SIG_SYS = 14;
    localparam int STS_RX_MABORT = 13;
    localparam int STS_RX_TABORT = 12;
    localparam int STS_SIG_TABORT = 11;
    localparam int STS_MST_PAR = 8;
    localparam int STS_CAP_LIST = 4;
    localparam int STS_INT = 3;
    localparam logic [15:0] STS_RESET = 16'h0010;
    localparam logic [15:0] STS_W1C_MASK = 16'hF900;
    localparam int STS_NFLAG = 6;
endpackage
`default_nettype wire

/* core/pccs_sticky_flags.sv */
// sticky status flags cleared by writing one, set wins over clear
`default_nettype none
module pccs_sticky_flags #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // set and clear
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    // state
    output logic [WIDTH-1:0] flag_o
);
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_o <= '0;
        end else begin
            flag_o <= set_i | (flag_o & ~clr_i);
        end
    end

    AST_SET_WINS: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (set_i != '0) |=> ((flag_o & $past(set_i)) == $past(set_i)))
        else $error("flag set lost against clear");
endmodule
`default_nettype wire

/* core/pccs_req_gate.sv */
// gates link requests and messages by the command enables
`default_nettype none
module pccs_req_gate (
    // enables
    input wire logic mem_space_en_i,
    input wire logic io_space_en_i,
    input wire logic bus_master_en_i,
    input wire logic err_report_en_i,
    // downstream requests
    input wire logic rx_mem_req_i,
    input wire logic rx_io_req_i,
    output logic rx_mem_accept_o,
    output logic rx_io_accept_o,
    output logic rx_ur_o,
    // upstream requests
    input wire logic mst_req_i,
    output logic mst_req_o,
    input wire logic err_fatal_req_i,
    input wire logic err_nonfatal_req_i,
    output logic err_fatal_o,
    output logic err_nonfatal_o
);
    assign rx_mem_accept_o = rx_mem_req_i & mem_space_en_i;
    assign rx_io_accept_o = rx_io_req_i & io_space_en_i;
    assign rx_ur_o = (rx_mem_req_i & ~mem_space_en_i)
                   | (rx_io_req_i & ~io_space_en_i);
    assign mst_req_o = mst_req_i & bus_master_en_i;
    assign err_fatal_o = err_fatal_req_i & err_report_en_i;
    assign err_nonfatal_o = err_nonfatal_req_i & err_report_en_i;
endmodule
`default_nettype wire

/* core/pccs_cfg_regs.sv */
// command and status configuration registers of the endpoint function
`default_nettype none
module pccs_cfg_regs (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // configuration access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [pccs_pkg::CFG_AW-1:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // link events
    input wire logic poisoned_tlp_rx_i,
    input wire logic poisoned_cpl_rx_i,
    input wire logic poisoned_wr_rx_i,
    input wire logic ur_cpl_rx_i,
    input wire logic ca_cpl_rx_i,
    input wire logic ca_cpl_sent_i,
    // downstream requests
    input wire logic rx_mem_req_i,
    input wire logic rx_io_req_i,
    output logic rx_mem_accept_o,
    output logic rx_io_accept_o,
    output logic rx_ur_o,
    // function requests and messages
    input wire logic mst_req_i,
    output logic mst_req_o,
    input wire logic err_fatal_req_i,
    input wire logic err_nonfatal_req_i,
    output logic err_fatal_o,
    output logic err_nonfatal_o,
    // interrupt and forwarding
    input wire logic dev_int_i,
    output logic intx_assert_o,
    output logic fwd_bad_parity_o,
    // command state
    output logic [15:0] cmd_o
);
    import pccs_pkg::*;

    logic [15:0] pci_command;
    logic [STS_NFLAG-1:0] sts_flag;
    logic [STS_NFLAG-1:0] sts_set;
    logic [STS_NFLAG-1:0] sts_clr;
    logic int_pend;
    logic cmd_hit;
    logic err_sent;
    logic [15:0] pci_status;

    // place the six sticky flags into their status bit positions
    function automatic logic [15:0] sts_image(input logic [STS_NFLAG-1:0] f,
                                              input logic ip);
        logic [15:0] s;
        s = STS_RESET;
        s[STS_DET_PAR] = f[5];
        s[STS_SIG_SYS] = f[4];
        s[STS_RX_MABORT] = f[3];
        s[STS_RX_TABORT] = f[2];
        s[STS_SIG_TABORT] = f[1];
        s[STS_MST_PAR] = f[0];
        s[STS_INT] = ip;
        return s;
    endfunction

    // gather the write-one-to-clear bits in flag order
    function automatic logic [STS_NFLAG-1:0] sts_pick(input logic [15:0] w);
        return {w[STS_DET_PAR], w[STS_SIG_SYS], w[STS_RX_MABORT],
                w[STS_RX_TABORT], w[STS_SIG_TABORT], w[STS_MST_PAR]};
    endfunction

    assign cmd_hit = (cfg_addr_i[CFG_AW-1:2] == CMD_OFF[CFG_AW-1:2]);
    assign pci_status = sts_image(sts_flag, int_pend);
    assign cmd_o = pci_command;

    // command register: only the writable mask stores, per byte lane
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pci_command <= CMD_RESET;
        end else if (cfg_wr_i && cmd_hit) begin
            if (cfg_be_i[0]) begin
                pci_command[7:0] <=
                    cfg_wdata_i[7:0] & CMD_RW_MASK[7:0];
            end
            if (cfg_be_i[1]) begin
                pci_command[15:8] <=
                    cfg_wdata_i[15:8] & CMD_RW_MASK[15:8];
            end
        end
    end

    // events that light the sticky flags
    assign err_sent = err_fatal_o | err_nonfatal_o;
    assign sts_set = {poisoned_tlp_rx_i,
                      err_sent,
                      ur_cpl_rx_i,
                      ca_cpl_rx_i,
                      ca_cpl_sent_i,
                      pci_command[CMD_PAR_RESP]
                        & (poisoned_cpl_rx_i | poisoned_wr_rx_i)};

    // status write: upper half of the dword, ones clear
    always_comb begin
        sts_clr = '0;
        if (cfg_wr_i && cmd_hit) begin
            sts_clr = sts_pick({cfg_be_i[3] ? cfg_wdata_i[31:24] : 8'h00,
                                cfg_be_i[2] ? cfg_wdata_i[23:16] : 8'h00}
                               & STS_W1C_MASK);
        end
    end

    pccs_sticky_flags #(
        .WIDTH(STS_NFLAG)
    ) u_flags (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .set_i(sts_set),
        .clr_i(sts_clr),
        .flag_o(sts_flag)
    );

    // interrupt status follows the function, disable only masks the pin
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_pend <= 1'b0;
            intx_assert_o <= 1'b0;
        end else begin
            int_pend <= dev_int_i;
            intx_assert_o <= dev_int_i & ~pci_command[CMD_INT_DIS];
        end
    end

    // poisoned writes go onward with bad parity, no enable involved
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fwd_bad_parity_o <= 1'b0;
        end else begin
            fwd_bad_parity_o <= poisoned_wr_rx_i;
        end
    end

    // read data one cycle after the request
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i && cmd_hit) begin
                cfg_rdata_o <= {pci_status, pci_command};
            end else if (cfg_rd_i) begin
                cfg_rdata_o <= 32'h0000_0000;
            end
        end
    end

    pccs_req_gate u_gate (
        .mem_space_en_i(pci_command[CMD_MEM_EN]),
        .io_space_en_i(pci_command[CMD_IO_EN]),
        .bus_master_en_i(pci_command[CMD_BUS_MST]),
        .err_report_en_i(pci_command[CMD_ERR_REP]),
        .rx_mem_req_i(rx_mem_req_i),
        .rx_io_req_i(rx_io_req_i),
        .rx_mem_accept_o(rx_mem_accept_o),
        .rx_io_accept_o(rx_io_accept_o),
        .rx_ur_o(rx_ur_o),
        .mst_req_i(mst_req_i),
        .mst_req_o(mst_req_o),
        .err_fatal_req_i(err_fatal_req_i),
        .err_nonfatal_req_i(err_nonfatal_req_i),
        .err_fatal_o(err_fatal_o),
        .err_nonfatal_o(err_nonfatal_o)
    );

    AST_CMD_RSVD_ZERO: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_wr_i && cmd_hit && cfg_be_i[1] |=> pci_command[15:11] == 5'h00)
        else $error("reserved command bits stored a write");

    AST_INT_DIS_WR: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_wr_i && cmd_hit && cfg_be_i[1]
        |=> pci_command[CMD_INT_DIS] == $past(cfg_wdata_i[CMD_INT_DIS]))
        else $error("interrupt disable did not take the write");

    AST_INTX_MASK: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        dev_int_i && !pci_command[CMD_INT_DIS] |=> intx_assert_o)
        else $error("enabled interrupt not signalled");

    AST_INTX_MASKED: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        pci_command[CMD_INT_DIS] |=> !intx_assert_o)
        else $error("disabled interrupt still signalled");

    AST_HARD_ZERO: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_rd_i && cmd_hit ##1 cfg_rvalid_o
        |-> cfg_rdata_o[CMD_FAST_B2B] == 1'b0
            && cfg_rdata_o[CMD_STEP] == 1'b0
            && cfg_rdata_o[CMD_PALETTE] == 1'b0
            && cfg_rdata_o[CMD_WR_INV] == 1'b0
            && cfg_rdata_o[CMD_SPECIAL] == 1'b0
            && cfg_rdata_o[CMD_IO_EN] == 1'b0)
        else $error("hardwired command bit read as one");

    AST_STS_FIXED: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_rd_i && cmd_hit ##1 cfg_rvalid_o
        |-> (cfg_rdata_o[31:16] & ~(STS_W1C_MASK | (16'h0001 << STS_INT)))
            == STS_RESET)
        else $error("fixed status bit read wrong");

    AST_ERR_SUPPRESS: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !pci_command[CMD_ERR_REP] |-> !err_fatal_o && !err_nonfatal_o)
        else $error("error message sent while reporting disabled");

    AST_ERR_PASS: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        pci_command[CMD_ERR_REP] |-> err_fatal_o == err_fatal_req_i
            && err_nonfatal_o == err_nonfatal_req_i)
        else $error("enabled error message not sent");

    AST_ERR_FLAG: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        err_fatal_o || err_nonfatal_o |=> pci_status[STS_SIG_SYS])
        else $error("sent error message not flagged");

    AST_PAR_BLOCKED: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !pci_command[CMD_PAR_RESP] && !pci_status[STS_MST_PAR]
        |=> !pci_status[STS_MST_PAR])
        else $error("parity flag set without response enable");

    AST_PAR_SET: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        pci_command[CMD_PAR_RESP] && (poisoned_cpl_rx_i || poisoned_wr_rx_i)
        |=> pci_status[STS_MST_PAR])
        else $error("parity flag missed a poisoned transfer");

    AST_FWD_POISON: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        poisoned_wr_rx_i |=> fwd_bad_parity_o)
        else $error("poisoned write not forwarded bad");

    AST_MST_GATE: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !pci_command[CMD_BUS_MST] |-> !mst_req_o)
        else $error("request issued without bus master enable");

    AST_MST_PASS: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        pci_command[CMD_BUS_MST] && mst_req_i |-> mst_req_o)
        else $error("enabled request not passed on");

    AST_MEM_UR: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        rx_mem_req_i |-> rx_mem_accept_o == pci_command[CMD_MEM_EN]
            && (pci_command[CMD_MEM_EN] || rx_ur_o))
        else $error("memory request answered wrongly");

    AST_IO_UR: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        rx_io_req_i |-> rx_ur_o && !rx_io_accept_o)
        else $error("io request not answered unsupported");

    AST_STS_NO_STORE: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(pci_status[STS_RX_MABORT]) |-> $past(ur_cpl_rx_i))
        else $error("status flag set by something other than its event");

    AST_STS_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !cfg_wr_i
        |=> (sts_flag & $past(sts_flag)) == $past(sts_flag))
        else $error("status flag dropped without a write");

    AST_RO_WRITE: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_wr_i && cmd_hit |=> (pci_command & ~CMD_RW_MASK) == 16'h0000
                                && pci_status[STS_CAP_LIST])
        else $error("write disturbed a read-only bit");

    AST_UNMAPPED_WR: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cfg_wr_i && !cmd_hit |=> $stable(pci_command))
        else $error("write elsewhere changed the command register");
endmodule
`default_nettype wire

/* tb/pccs_rc_model.sv */
// root complex model issuing configuration accesses
`default_nettype none
module pccs_rc_model (
    // clock
    input wire logic ref_clk_i,
    // configuration access
    output logic wr_o,
    output logic rd_o,
    output logic [pccs_pkg::CFG_AW-1:0] addr_o,
    output logic [3:0] be_o,
    output logic [31:0] wd_o,
    input wire logic [31:0] rd_i,
    input wire logic rv_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import pccs_pkg::*;
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = '0;
        be_o = 4'h0;
        wd_o = 32'h0;
    end
    // released lines show a changing pattern, not the last value
    task automatic idle();
        addr_o = ~addr_o;
        be_o = ~be_o;
        wd_o = ~wd_o;
    endtask
    task automatic cfg_write(input logic [11:0] a, input logic [3:0] b,
                             input logic [31:0] d);
        @(negedge ref_clk_i);
        wr_o = 1'b1;
        addr_o = a;
        be_o = b;
        wd_o = d;
        @(negedge ref_clk_i);
        wr_o = 1'b0;
        idle();
    endtask
    task automatic cfg_read(input logic [11:0] a, output logic [31:0] d,
                            output logic ok);
        @(negedge ref_clk_i);
        rd_o = 1'b1;
        addr_o = a;
        @(negedge ref_clk_i);
        rd_o = 1'b0;
        idle();
        ok = rv_i;
        d = rd_i;
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// random self-checking bench for the command and status registers
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pccs_pkg::*;
    logic clk, rst_b, wr, rd, rv, pt, pc, pw, ur, car, cas, mq, iq;
    logic ma, ia, uo, mr, mo, fa, nf, fo, no, di, ix, fw;
    logic [CFG_AW-1:0] ad;
    logic [3:0] be;
    logic [31:0] wd, rdat, got;
    logic [15:0] cmd, m_cmd, m_sts;
    logic ok;
    int n_mismatch, checked;
    pccs_rc_model rc (.ref_clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(ad),
        .be_o(be), .wd_o(wd), .rd_i(rdat), .rv_i(rv));
    pccs_cfg_regs dut (.ref_clk_i(clk), .rst_b_i(rst_b), .cfg_wr_i(wr),
        .cfg_rd_i(rd), .cfg_addr_i(ad), .cfg_be_i(be), .cfg_wdata_i(wd),
        .cfg_rdata_o(rdat), .cfg_rvalid_o(rv), .poisoned_tlp_rx_i(pt),
        .poisoned_cpl_rx_i(pc), .poisoned_wr_rx_i(pw), .ur_cpl_rx_i(ur),
        .ca_cpl_rx_i(car), .ca_cpl_sent_i(cas), .rx_mem_req_i(mq),
        .rx_io_req_i(iq), .rx_mem_accept_o(ma), .rx_io_accept_o(ia),
        .rx_ur_o(uo), .mst_req_i(mr), .mst_req_o(mo), .err_fatal_req_i(fa),
        .err_nonfatal_req_i(nf), .err_fatal_o(fo), .err_nonfatal_o(no),
        .dev_int_i(di), .intx_assert_o(ix), .fwd_bad_parity_o(fw),
        .cmd_o(cmd));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // writable command bits and clearable status flags
    task automatic do_write(input logic [3:0] b, input logic [31:0] d);
        logic [15:0] m;
        m = {{8{b[1]}}, {8{b[0]}}};
        m_cmd = (m_cmd & ~m) | (d[15:0] & m & 16'h0546);
        m = {{8{b[3]}}, {8{b[2]}}} & 16'hF900;
        m_sts = m_sts & ~(d[31:16] & m);
        rc.cfg_write(12'h004, b, d);
        chk(cmd, m_cmd);
    endtask
    task automatic do_read();
        rc.cfg_read(12'h004, got, ok);
        chk(ok, 1);
        chk(got, {m_sts, m_cmd});
        chk(ix, di & ~m_cmd[10]);
    endtask
    // one cycle of link events and function requests
    task automatic do_events();
        logic [31:0] r;
        r = $urandom;
        @(negedge clk);
        {pt, pc, pw, ur, car, cas} = r[5:0];
        {mq, iq, mr, fa, nf, di} = r[11:6];
        #1;
        chk(ma, mq & m_cmd[1]);
        chk(uo, (mq & ~m_cmd[1]) | iq);
        chk(ia, 0);
        chk(mo, mr & m_cmd[2]);
        chk({fo, no}, {fa, nf} & {2{m_cmd[8]}});
        m_sts[15] = m_sts[15] | pt;
        m_sts[14] = m_sts[14] | (m_cmd[8] & (fa | nf));
        m_sts[13:11] = m_sts[13:11] | {ur, car, cas};
        m_sts[8] = m_sts[8] | (m_cmd[6] & (pc | pw));
        m_sts[3] = di;
        @(negedge clk);
        chk(fw, pw);
        // message requests drop with the events; the interrupt level stays
        {pt, pc, pw, ur, car, cas, fa, nf} = 8'h00;
    endtask
    initial begin
        rst_b = 1'b0;
        {pt, pc, pw, ur, car, cas, mq, iq, mr, fa, nf, di} = 12'h0;
        m_cmd = 16'h0000;
        m_sts = 16'h0010;
        n_mismatch = 0;
        checked = 0;
        void'($urandom(32'h3CAB));
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        do_read();
        do_write(4'hF, 32'hFFFF_FFFF);
        do_read();
        do_events();
        do_read();
        rc.cfg_write(12'h010, 4'hF, 32'h0);
        rc.cfg_read(12'h008, got, ok);
        chk(got, 0);
        do_read();
        repeat (300) begin
            do_write(4'($urandom), $urandom);
            do_events();
            do_read();
        end
        // reset in mid-run brings back the defaults
        @(negedge clk);
        rst_b = 1'b0;
        di = 1'b0;
        m_cmd = 16'h0000;
        m_sts = 16'h0010;
        @(negedge clk);
        chk(cmd, 0);
        chk(ix, 0);
        rst_b = 1'b1;
        do_read();
        do_write(4'h3, 32'h0000_0546);
        do_events();
        do_read();
        summarize();
    end
    initial begin
        #1000000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
